// [tb/dpbr_fabric_model.sv]
/*
 User fabric model driving the write and read ports of one memory block.
 Assumes clk_sys is the bench clock and the bench calls its tasks.
*/
`timescale 1ns/1ps

module dpbr_fabric_model #(
    parameter int WR_WIDTH = 16,
    parameter int RD_WIDTH = 16
) (
    input wire logic clk_sys,
    output dpbr_pkg::dpbr_wr_port_s wr_port,
    output dpbr_pkg::dpbr_rd_port_s rd_port
);
    import dpbr_pkg::*;

    initial begin
        wr_port = '0;
        rd_port = '0;
    end

    // Narrow bit i onto its lane, all other lanes tied to zero
    function automatic logic [15:0] to_lanes(input logic [15:0] d);
        logic [15:0] b;
        b = 16'h0000;
        for (int i = 0; i < WR_WIDTH; i++) begin
            if (WR_WIDTH == 2) b[3 + 8 * i] = d[i];
            else if (WR_WIDTH == 4) b[1 + 4 * i] = d[i];
            else if (WR_WIDTH == 8) b[2 * i] = d[i];
            else b[i] = d[i];
        end
        return b;
    endfunction : to_lanes

    task automatic do_write(input logic [10:0] a, input logic [15:0] d,
        input logic [15:0] m, input logic ce, input logic en);
        @(negedge clk_sys);
        wr_port.write_address_bus <= a & 11'(4096 / WR_WIDTH - 1);
        wr_port.write_data_bus <= to_lanes(d);
        wr_port.write_mask_n <= (WR_WIDTH == 16) ? m : 16'h0000;
        wr_port.write_clock_enable <= ce;
        wr_port.write_enable <= en;
        wr_port.write_clock <= 1'b1;
        @(negedge clk_sys);
        // Released data lanes stop showing the written value
        wr_port.write_data_bus <= to_lanes(~d);
        wr_port.write_enable <= 1'b0;
        wr_port.write_clock <= 1'b0;
    endtask : do_write

    task automatic do_read(input logic [10:0] a, input logic ce,
        input logic en);
        @(negedge clk_sys);
        rd_port.read_address_bus <= a & 11'(4096 / RD_WIDTH - 1);
        rd_port.read_clock_enable <= ce;
        rd_port.read_enable <= en;
        rd_port.read_clock <= 1'b1;
        @(negedge clk_sys);
        rd_port.read_enable <= 1'b0;
        rd_port.read_clock <= 1'b0;
    endtask : do_read

endmodule : dpbr_fabric_model

// [tb/tb.sv]
/*
 Self-checking bench: a 16/16 block and an 8-write/4-read block.
 Assumes the fabric model drives the ports on falling clock edges.
*/
`timescale 1ns/1ps

module tb;
    import dpbr_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    dpbr_wr_port_s w16, w8;
    dpbr_rd_port_s r16, r4;
    logic [15:0] rd16, rd4;
    int mismatches = 0;
    int total_checks = 0;
    logic [10:0] row_a [4] = '{11'h000, 11'h001, 11'h0FF, 11'h07E};
    logic [15:0] row_d [4] = '{16'hA55A, 16'h0001, 16'hFFFF, 16'h8000};
    logic [10:0] nib_a [4] = '{11'h000, 11'h001, 11'h3FE, 11'h3FF};
    logic [3:0] nib_d [4] = '{4'h5, 4'hA, 4'hC, 4'h3};

    always #12.5 clk_sys = ~clk_sys;

    dpbr_fabric_model u_fab16 (
        .clk_sys(clk_sys), .wr_port(w16), .rd_port(r16));
    dpbr_block_ram u_dut (
        .clk_sys(clk_sys), .rst(rst), .wr_port(w16), .rd_port(r16),
        .read_data_bus(rd16));
    dpbr_fabric_model #(.WR_WIDTH(8), .RD_WIDTH(4)) u_fab8 (
        .clk_sys(clk_sys), .wr_port(w8), .rd_port(r4));
    dpbr_block_ram #(.WR_WIDTH(8), .RD_WIDTH(4)) u_mix (
        .clk_sys(clk_sys), .rst(rst), .wr_port(w8), .rd_port(r4),
        .read_data_bus(rd4));

    // Four-bit read lanes 13, 9, 5, 1
    function automatic logic [15:0] nib_bus(input logic [3:0] n);
        return {2'b00, n[3], 3'b000, n[2], 3'b000, n[1], 3'b000, n[0], 1'b0};
    endfunction : nib_bus

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: read data %h, want %h",
                $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #1000000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk(rd16, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            u_fab16.do_write(row_a[i], row_d[i], 16'h0000, 1'b1, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            u_fab16.do_read(row_a[i], 1'b1, 1'b1);
            chk(rd16, row_d[i]);
        end
        // Masked write keeps the high byte
        u_fab16.do_write(11'h000, 16'h0FF0, 16'hFF00, 1'b1, 1'b1);
        u_fab16.do_read(11'h000, 1'b1, 1'b1);
        chk(rd16, 16'hA5F0);
        // Masked write keeps the low byte, bit 0 included
        u_fab16.do_write(11'h000, 16'h1200, 16'h00FF, 1'b1, 1'b1);
        u_fab16.do_read(11'h000, 1'b1, 1'b1);
        chk(rd16, 16'h12F0);
        // Blocked writes: clock enable low, then enable low
        u_fab16.do_write(11'h001, 16'h1234, 16'h0000, 1'b0, 1'b1);
        u_fab16.do_write(11'h001, 16'h5678, 16'h0000, 1'b1, 1'b0);
        u_fab16.do_read(11'h001, 1'b1, 1'b1);
        chk(rd16, 16'h0001);
        // Blocked reads hold the output
        u_fab16.do_read(11'h0FF, 1'b0, 1'b1);
        chk(rd16, 16'h0001);
        u_fab16.do_read(11'h0FF, 1'b1, 1'b0);
        chk(rd16, 16'h0001);
        // Eight-bit writes read back as nibbles
        u_fab8.do_write(11'h000, 16'h00A5, 16'hFFFF, 1'b1, 1'b1);
        u_fab8.do_write(11'h1FF, 16'h003C, 16'hFFFF, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_fab8.do_read(nib_a[i], 1'b1, 1'b1);
            chk(rd4, nib_bus(nib_d[i]));
        end
        // Reset in mid-run clears read data
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        chk(rd16, 16'h0000);
        chk(rd4, 16'h0000);
        rst = 1'b0;
        u_fab16.do_read(11'h0FF, 1'b1, 1'b1);
        chk(rd16, 16'hFFFF);
        summarize();
    end

endmodule : tb

// [verilog/dpbr_block_ram.sv]
/*
 4 Kbit pseudo dual-port memory with separately sized write and read ports.
 Assumes the port clocks are levels synchronous to clk_sys, sampled on it,
 and that the user logic ties off unused bus lines and the write mask.
*/
`timescale 1ns/1ps

`include "dpbr_defs.svh"

// Operation
// - Holds 4096 bits; write and read widths are separate parameters.
// - Shapes 2048x2 to 256x16; address bits 10:0 down to 7:0.
// - Data buses are 16 bits, address 11 bits; unused lines carry nothing.
// - Four-bit shape uses bus bits 13, 9, 5, 1 and address 9:0.
// - Eight-bit shape uses even bus bits 14 to 0 and address 8:0.
// - The active-low write mask acts only in the 16-bit shape.
// - Write clock rise with write enable stores data at write address.
// - Read clock rise with read enable loads registered read data.
// - Masked 16-bit writes keep each bit whose mask line is high.
module dpbr_block_ram #(
    parameter int WR_WIDTH = `DPBR_WIDTH_16,
    parameter int RD_WIDTH = `DPBR_WIDTH_16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire dpbr_pkg::dpbr_wr_port_s wr_port,
    input wire dpbr_pkg::dpbr_rd_port_s rd_port,
    output logic [`DPBR_DATA_BUS_W-1:0] read_data_bus
);
    import dpbr_pkg::*;

    localparam int WR_SH = $clog2(WR_WIDTH);
    localparam int RD_SH = $clog2(RD_WIDTH);

    // ------------------------------------------------------------
    // Port clock edge detection
    // ------------------------------------------------------------
    logic wr_clk_q;
    logic rd_clk_q;
    logic wr_rise;
    logic rd_rise;
    logic wr_fire;
    logic rd_fire;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_clk_q <= 1'b0;
        end else begin
            wr_clk_q <= wr_port.write_clock;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_clk_q <= 1'b0;
        end else begin
            rd_clk_q <= rd_port.read_clock;
        end
    end

    assign wr_rise = wr_port.write_clock & ~wr_clk_q;
    assign rd_rise = rd_port.read_clock & ~rd_clk_q;
    assign wr_fire = wr_rise & wr_port.write_clock_enable
                     & wr_port.write_enable;
    assign rd_fire = rd_rise & rd_port.read_clock_enable
                     & rd_port.read_enable;

    // ------------------------------------------------------------
    // Address to bit index
    // ------------------------------------------------------------
    dpbr_bit_idx_t wr_base;
    dpbr_bit_idx_t rd_base;

    // Shifting into 12 bits drops address bits beyond the depth
    assign wr_base = dpbr_bit_idx_t'({1'b0, wr_port.write_address_bus}
                                     << WR_SH);
    assign rd_base = dpbr_bit_idx_t'({1'b0, rd_port.read_address_bus}
                                     << RD_SH);

    // ------------------------------------------------------------
    // Lane mapping
    // ------------------------------------------------------------
    logic [`DPBR_DATA_BUS_W-1:0] wr_narrow;
    logic [`DPBR_DATA_BUS_W-1:0] rd_data_q;
    logic [`DPBR_DATA_BUS_W-1:0] wr_keep;

    dpbr_lane_map #(
        .WIDTH(WR_WIDTH)
    ) u_wr_map (
        .narrow_in('0),
        .bus_in(wr_port.write_data_bus),
        .bus_out(),
        .narrow_out(wr_narrow)
    );

    dpbr_lane_map #(
        .WIDTH(RD_WIDTH)
    ) u_rd_map (
        .narrow_in(rd_data_q),
        .bus_in('0),
        .bus_out(read_data_bus),
        .narrow_out()
    );

    // Mask only counts in the 16-bit shape
    assign wr_keep = (WR_WIDTH == `DPBR_WIDTH_16) ?
                     wr_port.write_mask_n : '0;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic mem_q [0:`DPBR_MEM_BITS-1];

    always_ff @(posedge clk_sys) begin
        if (wr_fire) begin
            for (int i = 0; i < WR_WIDTH; i++) begin
                if (!wr_keep[i]) begin
                    mem_q[dpbr_bit_idx_t'(wr_base + dpbr_bit_idx_t'(i))]
                        <= wr_narrow[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registered read
    // ------------------------------------------------------------
    logic [`DPBR_DATA_BUS_W-1:0] rd_word;

    always_comb begin
        rd_word = '0;
        for (int i = 0; i < RD_WIDTH; i++) begin
            rd_word[i] = mem_q[dpbr_bit_idx_t'(rd_base
                                               + dpbr_bit_idx_t'(i))];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data_q <= `DPBR_RD_DATA_RST;
        end else if (rd_fire) begin
            rd_data_q <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    logic mem_bit0;
    logic mem_top;
    dpbr_bit_idx_t wr_top;
    logic [`DPBR_DATA_BUS_W-1:0] rd_lanes;
    logic [`DPBR_DATA_BUS_W-1:0] rd_probe;

    assign mem_bit0 = mem_q[wr_base];
    assign wr_top = dpbr_bit_idx_t'(wr_base
                                    + dpbr_bit_idx_t'(WR_WIDTH - 1));
    assign mem_top = mem_q[wr_top];

    always_comb begin
        rd_lanes = '0;
        rd_probe = '0;
        for (int i = 0; i < RD_WIDTH; i++) begin
            rd_lanes[dpbr_lane_pos(RD_WIDTH, i)] = 1'b1;
            rd_probe[i] = read_data_bus[dpbr_lane_pos(RD_WIDTH, i)];
        end
    end

    sequence wr_open_s;
        wr_fire && !wr_keep[0];
    endsequence

    sequence wr_blocked_s;
        wr_rise && !wr_port.write_clock_enable;
    endsequence

    sequence rd_load_s;
        rd_fire ##1 1'b1;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wr_store_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_open_s |=> mem_q[$past(wr_base)] == $past(wr_narrow[0]))
        else $error("write did not store data bit 0");

    wr_top_bit_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_fire && !wr_keep[WR_WIDTH-1]
        |=> mem_q[$past(wr_top)] == $past(wr_narrow[WR_WIDTH-1]))
        else $error("write did not store the top data bit");

    wr_gate_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_blocked_s |=> mem_q[$past(wr_base)] == $past(mem_bit0))
        else $error("write happened with clock enable low");

    wr_mask_keep_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_fire && WR_WIDTH == `DPBR_WIDTH_16
        && wr_port.write_mask_n[0]
        |=> mem_q[$past(wr_base)] == $past(mem_bit0))
        else $error("masked bit was overwritten");

    wr_mask_idle_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        WR_WIDTH != `DPBR_WIDTH_16 && wr_fire
        |=> mem_q[$past(wr_base)] == $past(wr_narrow[0]))
        else $error("mask acted outside the 16-bit shape");

    rd_load_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        rd_load_s |-> rd_data_q == $past(rd_word))
        else $error("read data did not load the addressed word");

    rd_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !rd_fire ##1 !rd_fire |=> $stable(rd_data_q)[*1])
        else $error("read data changed without a read");

    rd_lanes_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (read_data_bus & ~rd_lanes) == '0
        && rd_probe == rd_data_q)
        else $error("read data on wrong bus lines");

    rd_four_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        RD_WIDTH == `DPBR_WIDTH_4
        |-> read_data_bus[13] == rd_data_q[3]
        && read_data_bus[1] == rd_data_q[0])
        else $error("four-bit lanes misplaced");

    rd_eight_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        RD_WIDTH == `DPBR_WIDTH_8
        |-> read_data_bus[14] == rd_data_q[7]
        && read_data_bus[0] == rd_data_q[0])
        else $error("eight-bit lanes misplaced");

    idx_range_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        int'(wr_top) < `DPBR_MEM_BITS && int'(wr_top) >= int'(wr_base))
        else $error("write index outside storage");

endmodule : dpbr_block_ram

// [verilog/dpbr_defs.svh]
/*
 Fixed geometry of the 4 Kbit pseudo dual-port memory block.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef DPBR_DEFS_SVH
`define DPBR_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define DPBR_DATA_BUS_W 16
`define DPBR_ADDR_BUS_W 11

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
`define DPBR_MEM_BITS 4096
`define DPBR_BIT_IDX_W 12

// ----------------------------------------------------------------
// Port width settings and read data reset value
// ----------------------------------------------------------------
`define DPBR_WIDTH_2 2
`define DPBR_WIDTH_4 4
`define DPBR_WIDTH_8 8
`define DPBR_WIDTH_16 16
`define DPBR_RD_DATA_RST 16'h0000

`endif

// [verilog/dpbr_lane_map.sv]
/*
 Lane mapper: places narrow data onto the 16-bit bus and picks it back.
 Assumes WIDTH is 2, 4, 8 or 16; unused bus lines are driven to zero.
*/
`timescale 1ns/1ps

`include "dpbr_defs.svh"

module dpbr_lane_map #(
    parameter int WIDTH = `DPBR_WIDTH_16
) (
    input wire logic [`DPBR_DATA_BUS_W-1:0] narrow_in,
    input wire logic [`DPBR_DATA_BUS_W-1:0] bus_in,
    output logic [`DPBR_DATA_BUS_W-1:0] bus_out,
    output logic [`DPBR_DATA_BUS_W-1:0] narrow_out
);
    import dpbr_pkg::*;

    // ------------------------------------------------------------
    // Lane placement
    // ------------------------------------------------------------
    always_comb begin
        bus_out = '0;
        narrow_out = '0;
        for (int i = 0; i < WIDTH; i++) begin
            bus_out[dpbr_lane_pos(WIDTH, i)] = narrow_in[i];
            narrow_out[i] = bus_in[dpbr_lane_pos(WIDTH, i)];
        end
    end

endmodule : dpbr_lane_map

// [verilog/dpbr_pkg.sv]
/*
 Types and lane decoding shared by the memory block and its lane mapper.
 Assumes dpbr_defs.svh is on the include path.
*/
`include "dpbr_defs.svh"

package dpbr_pkg;

    // ------------------------------------------------------------
    // Port bundles
    // ------------------------------------------------------------
    typedef struct packed {
        logic write_clock;
        logic write_clock_enable;
        logic write_enable;
        logic [`DPBR_ADDR_BUS_W-1:0] write_address_bus;
        logic [`DPBR_DATA_BUS_W-1:0] write_data_bus;
        logic [`DPBR_DATA_BUS_W-1:0] write_mask_n;
    } dpbr_wr_port_s;

    typedef struct packed {
        logic read_clock;
        logic read_clock_enable;
        logic read_enable;
        logic [`DPBR_ADDR_BUS_W-1:0] read_address_bus;
    } dpbr_rd_port_s;

    typedef logic [`DPBR_BIT_IDX_W-1:0] dpbr_bit_idx_t;

    // ------------------------------------------------------------
    // Bus position of narrow data bit i for a given width
    // ------------------------------------------------------------
    function automatic int dpbr_lane_pos(input int width, input int i);
        unique case (width)
            `DPBR_WIDTH_2: return 3 + 8 * i;
            `DPBR_WIDTH_4: return 1 + 4 * i;
            `DPBR_WIDTH_8: return 2 * i;
            default: return i;
        endcase
    endfunction : dpbr_lane_pos

endpackage : dpbr_pkg
